/* File: rtl/mtrx_pkg.sv */
// Package for the table-read, exclusive-OR and subtract execution block
package mtrx_pkg;
    // ------------------------------------------------------------
    // Register map (AHB-Lite byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_ACC = 8'h00;
    localparam logic [7:0] OFF_TMODE = 8'h04;
    localparam logic [7:0] OFF_THP = 8'h08;
    localparam logic [7:0] OFF_THD = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_FILE = 8'h14;
    localparam logic [7:0] OFF_CMD = 8'h18;
    localparam logic [7:0] OFF_ROM_ADDR = 8'h1c;
    localparam logic [7:0] OFF_ROM_DATA = 8'h20;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 8;
    localparam int CMD_DEST_BIT = 11;
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_BUSY = 3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int ROM_AW = 11;
    localparam int ROM_DW = 14;
    localparam int TBL_CYCLES = 2;

    typedef enum logic [2:0] {
        OP_SUB_ACC_FROM_IMMEDIATE = 3'h0,
        OP_PROGRAM_TABLE_READ = 3'h1,
        OP_LOAD_TIMER0_MODE = 3'h2,
        OP_READ_TIMER0_MODE_OP = 3'h3,
        OP_XOR_ACC_WITH_FILE_REG = 3'h4,
        OP_XOR_IMMEDIATE_INTO_ACC = 3'h5
    } mtrx_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_TBL1 = 2'h1,
        ST_TBL2 = 2'h2
    } mtrx_fsm_t;

    typedef struct packed {
        logic [7:0] accumulator;
        logic [7:0] timer0_mode_reg;
        logic [7:0] table_high_pointer;
        logic [7:0] table_high_data;
        logic [7:0] file_reg;
        logic c;
        logic dc;
        logic z;
        mtrx_fsm_t fsm;
        logic [ROM_DW-1:0] rom_word;
        logic [ROM_AW-1:0] rom_addr;
        logic dp_act;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
    } mtrx_state_t;
endpackage

/* File: rtl/mtrx_core.sv */
// Execution block for subtract, table read, timer mode and exclusive-OR
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mtrx_core #(
    parameter int ROM_AW = mtrx_pkg::ROM_AW,
    parameter int ROM_DW = mtrx_pkg::ROM_DW
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    // ------------------------------------------------------------
    // Program memory, loaded by software through the bus
    // ------------------------------------------------------------
    logic [ROM_DW-1:0] rom [0:(1<<ROM_AW)-1];
    mtrx_pkg::mtrx_state_t s, next_s;
    logic take, wr, busy;
    logic [7:0] imm, res;
    logic [8:0] diff;
    logic [4:0] ldiff;
    logic [ROM_AW-1:0] taddr;
    mtrx_pkg::mtrx_op_t op;

    assign busy = (s.fsm != mtrx_pkg::ST_IDLE);
    // Bus stalls during a table read so no command overlaps it
    assign hreadyout = !(busy && s.dp_act);
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign take = hsel && hready && htrans[1];
    assign wr = s.dp_act && s.dp_write && hreadyout;
    assign imm = hwdata[7:0];
    assign op = mtrx_pkg::mtrx_op_t'(hwdata[mtrx_pkg::CMD_OP_LSB +: 3]);
    // Address is the low three pointer bits over the accumulator
    assign taddr =
        ROM_AW'({s.table_high_pointer[2:0], s.accumulator});
    assign diff = {1'b0, imm} - {1'b0, s.accumulator};
    assign ldiff = {1'b0, imm[3:0]} - {1'b0, s.accumulator[3:0]};

    always_ff @(posedge hclk) begin
        if (wr && s.dp_addr == mtrx_pkg::OFF_ROM_DATA) begin
            rom[s.rom_addr] <= hwdata[ROM_DW-1:0];
        end
    end

    // ------------------------------------------------------------
    // Read decode, shared by the address phase and a stalled data phase
    // ------------------------------------------------------------
    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input mtrx_pkg::mtrx_state_t st);
        logic [31:0] w;
        w = 32'h0;
        case (a)
            mtrx_pkg::OFF_ACC: w = {24'h0, st.accumulator};
            mtrx_pkg::OFF_TMODE: w = {24'h0, st.timer0_mode_reg};
            mtrx_pkg::OFF_THP: w = {24'h0, st.table_high_pointer};
            mtrx_pkg::OFF_THD: w = {24'h0, st.table_high_data};
            mtrx_pkg::OFF_FILE: w = {24'h0, st.file_reg};
            mtrx_pkg::OFF_STATUS:
                w = {28'h0, (st.fsm != mtrx_pkg::ST_IDLE), st.z, st.dc, st.c};
            mtrx_pkg::OFF_ROM_ADDR: w = {{(32-ROM_AW){1'b0}}, st.rom_addr};
            default: w = 32'h0;
        endcase
        return w;
    endfunction

    always_comb begin
        next_s = s;
        res = 8'h00;
        next_s.hrdata = 32'h0;
        if (hreadyout) begin
            next_s.dp_act = take;
            next_s.dp_write = hwrite;
            next_s.dp_addr = haddr[7:0];
            if (take && !hwrite) begin
                next_s.hrdata = rd_word(haddr[7:0], s);
            end
        end
        case (s.fsm)
            mtrx_pkg::ST_TBL1: begin
                next_s.rom_word = rom[taddr];
                next_s.fsm = mtrx_pkg::ST_TBL2;
            end
            mtrx_pkg::ST_TBL2: begin
                next_s.accumulator = s.rom_word[7:0];
                next_s.table_high_data = {2'b00, s.rom_word[13:8]};
                next_s.fsm = mtrx_pkg::ST_IDLE;
            end
            default: next_s.fsm = mtrx_pkg::ST_IDLE;
        endcase
        if (wr) begin
            case (s.dp_addr)
                mtrx_pkg::OFF_ACC: next_s.accumulator = hwdata[7:0];
                mtrx_pkg::OFF_THP: next_s.table_high_pointer = hwdata[7:0];
                mtrx_pkg::OFF_FILE: next_s.file_reg = hwdata[7:0];
                mtrx_pkg::OFF_ROM_ADDR: next_s.rom_addr = hwdata[ROM_AW-1:0];
                mtrx_pkg::OFF_ROM_DATA: next_s.rom_addr = s.rom_addr + 1'b1;
                mtrx_pkg::OFF_CMD: begin
                    case (op)
                        mtrx_pkg::OP_SUB_ACC_FROM_IMMEDIATE: begin
                            next_s.accumulator = diff[7:0];
                            next_s.c = !diff[8];
                            next_s.dc = !ldiff[4];
                            next_s.z = (diff[7:0] == 8'h00);
                        end
                        mtrx_pkg::OP_PROGRAM_TABLE_READ:
                            next_s.fsm = mtrx_pkg::ST_TBL1;
                        mtrx_pkg::OP_LOAD_TIMER0_MODE:
                            next_s.timer0_mode_reg = s.accumulator;
                        mtrx_pkg::OP_READ_TIMER0_MODE_OP:
                            next_s.accumulator = s.timer0_mode_reg;
                        mtrx_pkg::OP_XOR_ACC_WITH_FILE_REG: begin
                            res = s.accumulator ^ s.file_reg;
                            if (hwdata[mtrx_pkg::CMD_DEST_BIT]) begin
                                next_s.file_reg = res;
                            end else begin
                                next_s.accumulator = res;
                            end
                            next_s.z = (res == 8'h00);
                        end
                        mtrx_pkg::OP_XOR_IMMEDIATE_INTO_ACC: begin
                            res = s.accumulator ^ imm;
                            next_s.accumulator = res;
                            next_s.z = (res == 8'h00);
                        end
                        default: next_s.z = s.z;
                    endcase
                end
                default: next_s.z = s.z;
            endcase
        end
        // A read held behind a table read returns the finished result
        if (!hreadyout && s.dp_act && !s.dp_write) begin
            next_s.hrdata = rd_word(s.dp_addr, next_s);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic cmd_wr;
    assign cmd_wr = wr && s.dp_addr == mtrx_pkg::OFF_CMD;
    a_sub_result: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_SUB_ACC_FROM_IMMEDIATE |=> s.accumulator ==
        8'($past(hwdata[7:0]) - $past(s.accumulator)))
        else $error("subtract result wrong");
    a_sub_carry: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_SUB_ACC_FROM_IMMEDIATE |=>
        s.c == ($past(hwdata[7:0]) >= $past(s.accumulator)))
        else $error("subtract carry wrong");
    a_tbl_low: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_PROGRAM_TABLE_READ |=> ##1
        s.fsm == mtrx_pkg::ST_TBL2 ##1
        s.accumulator == $past(s.rom_word[7:0]))
        else $error("table low byte wrong");
    a_tbl_high: assert property (@(posedge hclk) disable iff (!hresetn)
        s.fsm == mtrx_pkg::ST_TBL2 |=>
        s.table_high_data == {2'b00, $past(s.rom_word[13:8])})
        else $error("table high bits wrong");
    a_tbl_two: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_PROGRAM_TABLE_READ |=> busy [*2] ##1 !busy)
        else $error("table read length wrong");
    a_tmode_load: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_LOAD_TIMER0_MODE |=>
        s.timer0_mode_reg == $past(s.accumulator))
        else $error("timer mode load wrong");
    a_tmode_read: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_READ_TIMER0_MODE_OP |=>
        s.accumulator == $past(s.timer0_mode_reg) && $stable(s.timer0_mode_reg))
        else $error("timer mode read wrong");
    a_xor_dest: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_XOR_ACC_WITH_FILE_REG &&
        hwdata[mtrx_pkg::CMD_DEST_BIT] |=> $stable(s.accumulator) &&
        s.file_reg == ($past(s.accumulator) ^ $past(s.file_reg)))
        else $error("register xor wrong");
    a_xor_imm: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_XOR_IMMEDIATE_INTO_ACC |=>
        s.accumulator == ($past(s.accumulator) ^ $past(hwdata[7:0])))
        else $error("immediate xor wrong");
    a_xor_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_XOR_IMMEDIATE_INTO_ACC |=>
        s.z == (s.accumulator == 8'h00) && $stable(s.c))
        else $error("xor zero flag wrong");
    a_xor_acc: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_XOR_ACC_WITH_FILE_REG &&
        !hwdata[mtrx_pkg::CMD_DEST_BIT] |=> $stable(s.file_reg) &&
        s.accumulator == ($past(s.accumulator) ^ $past(s.file_reg)))
        else $error("register xor into accumulator wrong");
    a_xor_reg_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_XOR_ACC_WITH_FILE_REG |=>
        $stable(s.c) && $stable(s.dc) && s.z ==
        (($past(s.accumulator) ^ $past(s.file_reg)) == 8'h00))
        else $error("register xor zero flag wrong");
    a_sub_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && op == mtrx_pkg::OP_SUB_ACC_FROM_IMMEDIATE |=>
        s.z == (s.accumulator == 8'h00))
        else $error("subtract zero flag wrong");
endmodule
`default_nettype wire

/* File: tb/mtrx_core_bench.sv */
// Testbench for the table-read, exclusive-OR and subtract block
`timescale 1ns/1ps
`default_nettype none
module mcu_table_read_xor_subtract_ops_bench;
    // ------------------------------------------------------------
    // Bus signals and bookkeeping
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] op;
        logic dest;
        logic [7:0] imm;
        logic [7:0] acc;
        logic [7:0] file;
        logic [7:0] e_acc;
        logic [7:0] e_file;
        logic [3:0] e_st;
    } mtrx_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] rd;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int waits = 0;
    // C is set by rows[1] and rows[2] and must survive the exclusive-OR rows
    // The last row is an unused command code that must change nothing
    mtrx_row_t rows [8] = '{
        '{3'h0, 1'b0, 8'h05, 8'h06, 8'h00, 8'hff, 8'h00, 4'h0},
        '{3'h0, 1'b0, 8'h06, 8'h05, 8'h00, 8'h01, 8'h00, 4'h3},
        '{3'h0, 1'b0, 8'h33, 8'h33, 8'h00, 8'h00, 8'h00, 4'h7},
        '{3'h4, 1'b1, 8'h00, 8'hf0, 8'ha5, 8'hf0, 8'h55, 4'h3},
        '{3'h4, 1'b0, 8'h00, 8'ha5, 8'ha5, 8'h00, 8'ha5, 4'h7},
        '{3'h5, 1'b0, 8'ha5, 8'hf0, 8'h11, 8'h55, 8'h11, 4'h3},
        '{3'h5, 1'b0, 8'hff, 8'hff, 8'h11, 8'h00, 8'h11, 4'h7},
        '{3'h6, 1'b0, 8'h12, 8'h34, 8'h56, 8'h34, 8'h56, 4'h7}};
    always #25 hclk = ~hclk;
    mtrx_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Sampled mid-cycle so a combinational ready is settled
    task automatic wait_ready();
        logic r;
        do begin
            @(negedge hclk);
            r = hreadyout;
            rd = hrdata;
            if (r !== 1'b1) waits++;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic rdchk(input string name, input logic [7:0] a,
                         input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    task automatic cmd(input logic [2:0] op, input logic d,
                       input logic [7:0] imm);
        xfer(1'b1, mtrx_pkg::OFF_CMD, (32'(op) << mtrx_pkg::CMD_OP_LSB) |
             (32'(d) << mtrx_pkg::CMD_DEST_BIT) | {24'h0, imm});
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("acc rst", mtrx_pkg::OFF_ACC, 32'h0);
        rdchk("status rst", mtrx_pkg::OFF_STATUS, 32'h0);
        rdchk("tmode rst", mtrx_pkg::OFF_TMODE, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            xfer(1'b1, mtrx_pkg::OFF_ACC, {24'h0, rows[i].acc});
            xfer(1'b1, mtrx_pkg::OFF_FILE, {24'h0, rows[i].file});
            cmd(rows[i].op, rows[i].dest, rows[i].imm);
            rdchk("acc", mtrx_pkg::OFF_ACC, {24'h0, rows[i].e_acc});
            rdchk("file", mtrx_pkg::OFF_FILE, {24'h0, rows[i].e_file});
            rdchk("status", mtrx_pkg::OFF_STATUS, {28'h0, rows[i].e_st});
        end
        $display("test table rows done");
        xfer(1'b1, mtrx_pkg::OFF_ACC, 32'haa);
        cmd(3'h2, 1'b0, 8'h00);
        xfer(1'b1, mtrx_pkg::OFF_ACC, 32'h12);
        xfer(1'b1, mtrx_pkg::OFF_TMODE, 32'hff);
        rdchk("tmode", mtrx_pkg::OFF_TMODE, 32'haa);
        cmd(3'h3, 1'b0, 8'h00);
        rdchk("acc tmode", mtrx_pkg::OFF_ACC, 32'haa);
        rdchk("tmode kept", mtrx_pkg::OFF_TMODE, 32'haa);
        rdchk("unmapped", 8'h24, 32'h0);
        $display("test timer mode done");
        // Pointer bits above bit 2 must not reach the address
        xfer(1'b1, mtrx_pkg::OFF_ROM_ADDR, 32'h234);
        xfer(1'b1, mtrx_pkg::OFF_ROM_DATA, 32'h35aa);
        xfer(1'b1, mtrx_pkg::OFF_ROM_DATA, 32'h0155);
        rdchk("rom addr", mtrx_pkg::OFF_ROM_ADDR, 32'h236);
        xfer(1'b1, mtrx_pkg::OFF_THP, 32'h0a);
        xfer(1'b1, mtrx_pkg::OFF_ACC, 32'h34);
        cmd(3'h1, 1'b0, 8'h00);
        waits = 0;
        rdchk("acc table", mtrx_pkg::OFF_ACC, 32'haa);
        chk("stall", 32'(mtrx_pkg::TBL_CYCLES - 1), 32'(waits));
        rdchk("high data", mtrx_pkg::OFF_THD, 32'h35);
        xfer(1'b1, mtrx_pkg::OFF_ACC, 32'h35);
        cmd(3'h1, 1'b0, 8'h00);
        rdchk("acc table2", mtrx_pkg::OFF_ACC, 32'h55);
        rdchk("high data2", mtrx_pkg::OFF_THD, 32'h01);
        $display("test table read done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("acc rst2", mtrx_pkg::OFF_ACC, 32'h0);
        rdchk("tmode rst2", mtrx_pkg::OFF_TMODE, 32'h0);
        $display("test mid reset done");
        results();
    end
endmodule
`default_nettype wire
